// ==== hdl/uart_rx_wake.sv ====
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`include "uart_rx_defs.svh"

module uart_rx_wake (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        rx_line,
    input  wire logic        sleep_mode,
    output logic             irq_req,
    output logic             irq_high_prio
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    uart_rx_pkg::ctrl_s     ctrl_reg;
    uart_rx_pkg::ctrl_s     ctrl_next;
    uart_rx_pkg::rx_char_s  buf_reg;
    uart_rx_pkg::rx_char_s  buf_next;
    uart_rx_pkg::rx_char_s  char_in;
    uart_rx_pkg::baud_cfg_s baud_cfg;
    uart_rx_pkg::rx_state_e state_reg;
    uart_rx_pkg::rx_state_e state_next;

    logic        rx_flag_reg;
    logic        rx_flag_next;
    logic        overrun_reg;
    logic        overrun_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_o_reg;
    logic [31:0] dat_o_next;
    logic        irq_reg;
    logic        irq_next;
    logic        prio_reg;
    logic        prio_next;

    logic [3:0]  tick_cnt_reg;
    logic [3:0]  tick_cnt_next;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  bit_cnt_next;
    logic [8:0]  shift_reg;
    logic [8:0]  shift_next;
    logic        line_prev_reg;
    logic        wake_seen_reg;
    logic        wake_seen_next;

    logic        line;
    logic        sample_tick;
    logic        baud_run;
    logic        rx_allowed;
    logic        wake_active;
    logic        line_fell;
    logic        line_rose;
    logic [3:0]  char_bits;
    logic        char_done;
    logic        wake_fall;
    logic        wake_rise;
    logic        bus_req;
    logic        bus_wr;
    logic        bus_rd;
    logic        data_read;
    logic        keep_char;
    logic [7:0]  rd_byte;

    // ----------------------------------------
    // Line sampling and baud clock
    // ----------------------------------------

    // Two flops ahead of any use of the pin
    rx_line_sync #(
        .STAGES (2)
    ) u_sync (
        .clk       (clk),
        .rst       (rst),
        .rx_line   (rx_line),
        .line_sync (line)
    );

    always_comb begin
        baud_run = ctrl_reg.port_enable && !ctrl_reg.clocked_mode_select && !sleep_mode;
        baud_cfg.high_speed   = ctrl_reg.baud_high_speed;
        baud_cfg.wide_counter = ctrl_reg.baud_wide_counter;
        baud_cfg.divisor      = {ctrl_reg.divisor_high, ctrl_reg.divisor_low};
    end

    baud_tick_gen #(
        .DIV_W (16)
    ) u_baud (
        .clk         (clk),
        .rst         (rst),
        .run         (baud_run),
        .cfg         (baud_cfg),
        .sample_tick (sample_tick)
    );

    // ----------------------------------------
    // Receiver state machine
    // ----------------------------------------

    // Line edges and permission terms
    always_comb begin
        line_fell = line_prev_reg && !line;
        line_rose = !line_prev_reg && line;
        rx_allowed = ctrl_reg.port_enable && !ctrl_reg.clocked_mode_select
                     && ctrl_reg.continuous_rx_enable && !overrun_reg && !sleep_mode;
        wake_active = ctrl_reg.wake_on_break_enable && ctrl_reg.port_enable
                      && !ctrl_reg.clocked_mode_select;
        char_bits = ctrl_reg.rx_ninth_bit_enable ? `NINE_BITS : `WORD_BITS;
    end

    // Next state of the receiver
    always_comb begin
        state_next     = state_reg;
        tick_cnt_next  = tick_cnt_reg;
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        wake_seen_next = wake_seen_reg;
        char_done      = 1'b0;
        wake_fall      = 1'b0;
        wake_rise      = 1'b0;
        case (state_reg)
            uart_rx_pkg::ST_IDLE: begin
                if (wake_active) begin
                    state_next     = uart_rx_pkg::ST_WAKE;
                    wake_seen_next = 1'b0;
                end else if (rx_allowed && line_fell) begin
                    state_next    = uart_rx_pkg::ST_START;
                    tick_cnt_next = 4'h0;
                end
            end
            uart_rx_pkg::ST_START: begin
                if (!rx_allowed || wake_active) begin
                    state_next = uart_rx_pkg::ST_IDLE;
                end else if (sample_tick) begin
                    if (tick_cnt_reg == `SAMPLE_MID) begin
                        // A glitch shorter than half a bit is dropped
                        state_next    = line ? uart_rx_pkg::ST_IDLE : uart_rx_pkg::ST_DATA;
                        tick_cnt_next = 4'h0;
                        bit_cnt_next  = 4'h0;
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 4'h1;
                    end
                end
            end
            uart_rx_pkg::ST_DATA: begin
                if (!rx_allowed || wake_active) begin
                    state_next = uart_rx_pkg::ST_IDLE;
                end else if (sample_tick) begin
                    tick_cnt_next = tick_cnt_reg + 4'h1;
                    if (tick_cnt_reg == `SAMPLE_LAST) begin
                        shift_next   = {line, shift_reg[8:1]};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg + 4'h1 == char_bits) begin
                            state_next = uart_rx_pkg::ST_STOP;
                        end
                    end
                end
            end
            uart_rx_pkg::ST_STOP: begin
                if (!rx_allowed || wake_active) begin
                    state_next = uart_rx_pkg::ST_IDLE;
                end else if (sample_tick) begin
                    tick_cnt_next = tick_cnt_reg + 4'h1;
                    if (tick_cnt_reg == `SAMPLE_LAST) begin
                        char_done  = 1'b1;
                        state_next = uart_rx_pkg::ST_IDLE;
                    end
                end
            end
            uart_rx_pkg::ST_WAKE: begin
                if (!wake_active) begin
                    state_next = uart_rx_pkg::ST_IDLE;
                end else if (!wake_seen_reg && line_fell) begin
                    wake_fall      = 1'b1;
                    wake_seen_next = 1'b1;
                end else if (wake_seen_reg && line_rose) begin
                    wake_rise      = 1'b1;
                    wake_seen_next = 1'b0;
                    state_next     = uart_rx_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = uart_rx_pkg::ST_IDLE;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg     <= uart_rx_pkg::ST_IDLE;
            tick_cnt_reg  <= 4'h0;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 9'h000;
            line_prev_reg <= `LINE_IDLE;
            wake_seen_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            tick_cnt_reg  <= tick_cnt_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            line_prev_reg <= line;
            wake_seen_reg <= wake_seen_next;
        end
    end

    // ----------------------------------------
    // Register file and bus slave
    // ----------------------------------------

    // Character as it leaves the shifter
    always_comb begin
        char_in.data    = ctrl_reg.rx_ninth_bit_enable ? shift_reg[7:0] : shift_reg[8:1];
        char_in.ninth   = ctrl_reg.rx_ninth_bit_enable ? shift_reg[8] : 1'b0;
        char_in.framing = !line;
        keep_char = !(ctrl_reg.address_detect_enable && ctrl_reg.rx_ninth_bit_enable
                      && !char_in.ninth);
    end

    // Next values of software-visible state
    always_comb begin
        ctrl_next    = ctrl_reg;
        buf_next     = buf_reg;
        rx_flag_next = rx_flag_reg;
        overrun_next = overrun_reg;
        rd_byte      = `REG_RESET;
        bus_req      = cyc_i && stb_i && !ack_reg;
        bus_wr       = bus_req && we_i && sel_i[0];
        bus_rd       = bus_req && !we_i;
        data_read    = 1'b0;

        // Address decode; unmapped offsets read zero and ignore writes
        if (adr_i == `OFS_IRQ_GLOBAL) begin
            rd_byte[`GLOBAL_IRQ_EN_BIT] = ctrl_reg.global_irq_enable;
            rd_byte[`PERIPH_IRQ_EN_BIT] = ctrl_reg.peripheral_irq_enable;
            if (bus_wr) begin
                ctrl_next.global_irq_enable     = dat_i[`GLOBAL_IRQ_EN_BIT];
                ctrl_next.peripheral_irq_enable = dat_i[`PERIPH_IRQ_EN_BIT];
            end
        end else if (adr_i == `OFS_IRQ_FLAGS) begin
            // Flag is read-only; only a data read clears it
            rd_byte[`RX_IRQ_BIT] = rx_flag_reg;
        end else if (adr_i == `OFS_IRQ_ENABLES) begin
            rd_byte[`RX_IRQ_BIT] = ctrl_reg.rx_irq_enable;
            if (bus_wr) begin
                ctrl_next.rx_irq_enable = dat_i[`RX_IRQ_BIT];
            end
        end else if (adr_i == `OFS_IRQ_PRIORITIES) begin
            rd_byte[`RX_IRQ_BIT] = ctrl_reg.rx_irq_priority;
            if (bus_wr) begin
                ctrl_next.rx_irq_priority = dat_i[`RX_IRQ_BIT];
            end
        end else if (adr_i == `OFS_RX_STATUS) begin
            rd_byte[`PORT_ENABLE_BIT] = ctrl_reg.port_enable;
            rd_byte[`NINTH_EN_BIT]    = ctrl_reg.rx_ninth_bit_enable;
            rd_byte[`CONT_RX_EN_BIT]  = ctrl_reg.continuous_rx_enable;
            rd_byte[`ADDR_DET_EN_BIT] = ctrl_reg.address_detect_enable;
            rd_byte[`FRAMING_ERR_BIT] = buf_reg.framing;
            rd_byte[`OVERRUN_ERR_BIT] = overrun_reg;
            rd_byte[`NINTH_VAL_BIT]   = buf_reg.ninth;
            if (bus_wr) begin
                ctrl_next.port_enable           = dat_i[`PORT_ENABLE_BIT];
                ctrl_next.rx_ninth_bit_enable   = dat_i[`NINTH_EN_BIT];
                ctrl_next.continuous_rx_enable  = dat_i[`CONT_RX_EN_BIT];
                ctrl_next.address_detect_enable = dat_i[`ADDR_DET_EN_BIT];
                if (!dat_i[`CONT_RX_EN_BIT]) begin
                    overrun_next     = 1'b0;
                    buf_next.framing = 1'b0;
                end
            end
        end else if (adr_i == `OFS_RX_DATA) begin
            rd_byte   = buf_reg.data;
            data_read = bus_rd;
        end else if (adr_i == `OFS_TX_STATUS) begin
            rd_byte[`CLOCKED_MODE_BIT] = ctrl_reg.clocked_mode_select;
            rd_byte[`HIGH_SPEED_BIT]   = ctrl_reg.baud_high_speed;
            if (bus_wr) begin
                ctrl_next.clocked_mode_select = dat_i[`CLOCKED_MODE_BIT];
                ctrl_next.baud_high_speed     = dat_i[`HIGH_SPEED_BIT];
            end
        end else if (adr_i == `OFS_BAUD_CONTROL) begin
            rd_byte[`RX_IDLE_BIT]      = (state_reg == uart_rx_pkg::ST_IDLE);
            rd_byte[`WIDE_COUNTER_BIT] = ctrl_reg.baud_wide_counter;
            rd_byte[`WAKE_ENABLE_BIT]  = ctrl_reg.wake_on_break_enable;
        end else if (adr_i == `OFS_DIVISOR_HIGH) begin
            rd_byte = ctrl_reg.divisor_high;
            if (bus_wr) begin
                ctrl_next.divisor_high = dat_i[7:0];
            end
        end else if (adr_i == `OFS_DIVISOR_LOW) begin
            rd_byte = ctrl_reg.divisor_low;
            if (bus_wr) begin
                ctrl_next.divisor_low = dat_i[7:0];
            end
        end

        if (data_read) begin
            rx_flag_next = 1'b0;
        end

        if (wake_rise) begin
            ctrl_next.wake_on_break_enable = 1'b0;
        end
        // Software write lands last, so a fresh set is never lost
        if (bus_wr && adr_i == `OFS_BAUD_CONTROL) begin
            ctrl_next.baud_wide_counter    = dat_i[`WIDE_COUNTER_BIT];
            ctrl_next.wake_on_break_enable = dat_i[`WAKE_ENABLE_BIT];
        end

        if (wake_fall) begin
            rx_flag_next = 1'b1;
        end

        if (char_done && keep_char) begin
            if (rx_flag_reg && !data_read) begin
                overrun_next = 1'b1;
            end else begin
                buf_next     = char_in;
                rx_flag_next = 1'b1;
            end
        end

        irq_next  = rx_flag_next && ctrl_next.rx_irq_enable
                    && ctrl_next.peripheral_irq_enable && ctrl_next.global_irq_enable;
        prio_next = ctrl_next.rx_irq_priority;

        // One wait state, then ack for a single cycle
        ack_next   = bus_req;
        dat_o_next = bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // Register file registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg    <= '0;
            buf_reg     <= '0;
            rx_flag_reg <= 1'b0;
            overrun_reg <= 1'b0;
            ack_reg     <= 1'b0;
            dat_o_reg   <= 32'h00000000;
            irq_reg     <= 1'b0;
            prio_reg    <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            buf_reg     <= buf_next;
            rx_flag_reg <= rx_flag_next;
            overrun_reg <= overrun_next;
            ack_reg     <= ack_next;
            dat_o_reg   <= dat_o_next;
            irq_reg     <= irq_next;
            prio_reg    <= prio_next;
        end
    end

    // Outputs straight from flops
    assign ack_o         = ack_reg;
    assign dat_o         = dat_o_reg;
    assign irq_req       = irq_reg;
    assign irq_high_prio = prio_reg;

endmodule

// ==== hdl/uart_rx_defs.svh ====
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_IRQ_GLOBAL     8'h00
`define OFS_IRQ_FLAGS      8'h04
`define OFS_IRQ_ENABLES    8'h08
`define OFS_IRQ_PRIORITIES 8'h0c
`define OFS_RX_STATUS      8'h10
`define OFS_RX_DATA        8'h14
`define OFS_TX_STATUS      8'h18
`define OFS_BAUD_CONTROL   8'h1c
`define OFS_DIVISOR_HIGH   8'h20
`define OFS_DIVISOR_LOW    8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GLOBAL_IRQ_EN_BIT  7
`define PERIPH_IRQ_EN_BIT  6
`define RX_IRQ_BIT         5
`define PORT_ENABLE_BIT    7
`define NINTH_EN_BIT       6
`define CONT_RX_EN_BIT     4
`define ADDR_DET_EN_BIT    3
`define FRAMING_ERR_BIT    2
`define OVERRUN_ERR_BIT    1
`define NINTH_VAL_BIT      0
`define CLOCKED_MODE_BIT   4
`define HIGH_SPEED_BIT     2
`define RX_IDLE_BIT        6
`define WIDE_COUNTER_BIT   3
`define WAKE_ENABLE_BIT    1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define REG_RESET          8'h00
`define LINE_IDLE          1'b1
`define SAMPLE_MID         4'h7
`define SAMPLE_LAST        4'hf
`define SLOW_PRESCALE      2'h3
`define WORD_BITS          4'h8
`define NINE_BITS          4'h9

`endif

// ==== hdl/uart_rx_pkg.sv ====
package uart_rx_pkg;

    // Receiver states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_START = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_STOP  = 5'b01000,
        ST_WAKE  = 5'b10000
    } rx_state_e;

    // Baud generator setup
    typedef struct packed {
        logic        high_speed;
        logic        wide_counter;
        logic [15:0] divisor;
    } baud_cfg_s;

    // One received character
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       framing;
    } rx_char_s;

    // Software-held control bits
    typedef struct packed {
        logic       global_irq_enable;
        logic       peripheral_irq_enable;
        logic       rx_irq_enable;
        logic       rx_irq_priority;
        logic       port_enable;
        logic       rx_ninth_bit_enable;
        logic       continuous_rx_enable;
        logic       address_detect_enable;
        logic       clocked_mode_select;
        logic       baud_high_speed;
        logic       baud_wide_counter;
        logic       wake_on_break_enable;
        logic [7:0] divisor_high;
        logic [7:0] divisor_low;
    } ctrl_s;

endpackage

// ==== hdl/rx_line_sync.sv ====
`timescale 1ns/100ps
`include "uart_rx_defs.svh"

module rx_line_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rx_line,
    output logic      line_sync
);

    logic [STAGES-1:0] chain_reg;
    logic [STAGES-1:0] chain_next;

    // Fewer than two stages would not settle metastability
    generate
        if (STAGES < 2) begin : g_check
            $error("rx_line_sync needs at least two stages");
        end
    endgenerate

    // Shift the pin along the chain
    always_comb begin
        chain_next = {chain_reg[STAGES-2:0], rx_line};
    end

    // Idle line is high, so reset to high
    always_ff @(posedge clk) begin
        if (rst) begin
            chain_reg <= {STAGES{`LINE_IDLE}};
        end else begin
            chain_reg <= chain_next;
        end
    end

    assign line_sync = chain_reg[STAGES-1];

endmodule

// ==== hdl/baud_tick_gen.sv ====
`timescale 1ns/100ps
`include "uart_rx_defs.svh"

module baud_tick_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  run,
    input  wire uart_rx_pkg::baud_cfg_s cfg,
    output logic                       sample_tick
);

    logic [DIV_W-1:0] count_reg;
    logic [DIV_W-1:0] count_next;
    logic [1:0]       pre_reg;
    logic [1:0]       pre_next;
    logic             tick_reg;
    logic             tick_next;
    logic [DIV_W-1:0] reload;
    logic             slow_mode;

    // The divisor pair is sixteen bits wide
    generate
        if (DIV_W < 16) begin : g_check
            $error("baud_tick_gen divisor counter too narrow");
        end
    endgenerate

    always_comb begin
        reload    = cfg.wide_counter ? DIV_W'(cfg.divisor) : DIV_W'(cfg.divisor[7:0]);
        slow_mode = !cfg.high_speed && !cfg.wide_counter;
        count_next = count_reg;
        pre_next   = pre_reg;
        tick_next  = 1'b0;
        if (!run) begin
            count_next = reload;
            pre_next   = 2'h0;
        end else if (count_reg == '0) begin
            count_next = reload;
            // Slow rate is divided down so the sampler always sees x16
            if (slow_mode) begin
                pre_next  = pre_reg + 2'h1;
                tick_next = (pre_reg == `SLOW_PRESCALE);
            end else begin
                tick_next = 1'b1;
            end
        end else begin
            count_next = count_reg - DIV_W'(1);
        end
    end

    // Counter registers
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            pre_reg   <= 2'h0;
            tick_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            pre_reg   <= pre_next;
            tick_reg  <= tick_next;
        end
    end

    assign sample_tick = tick_reg;

endmodule

// ==== bench/uart_rx_checker.sv ====
`timescale 1ns/100ps
// Watches the bus answer and the request outputs only
module uart_rx_checker (
    input logic        clk,
    input logic        rst,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        we_i,
    input logic [7:0]  adr_i,
    input logic [31:0] dat_o,
    input logic        ack_o,
    input logic        irq_req,
    input logic        irq_high_prio
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    // Bus answer: one pulse, one cycle after a taken request
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("long ack");
    property p_cause; $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
    a_cause: assert property (p_cause) else $error("stray ack");
    // Read data stays zero outside a read answer, so stale bytes never leak
    property p_idle; !ack_o || we_i |-> dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data not zero");
    property p_hole; ack_o && adr_i > 8'h24 |-> dat_o == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped data");
    // Buffer read drops the request two edges later
    property p_clr; cyc_i && stb_i && !ack_o && !we_i && adr_i == 8'h14 |-> ##2 !irq_req; endproperty
    a_clr: assert property (p_clr) else $error("irq after read");
    property p_prio; !$stable(irq_high_prio) |-> $past(cyc_i && stb_i && we_i); endproperty
    a_prio: assert property (p_prio) else $error("priority moved");
    property p_rst; $fell(rst) |-> !ack_o && !irq_req && !irq_high_prio; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind uart_rx_wake uart_rx_checker uart_rx_checker_i (.clk(clk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_req(irq_req), .irq_high_prio(irq_high_prio));

// ==== bench/serial_sender.sv ====
`timescale 1ns/100ps
// Remote sender; line idles high as with a pull-up
module serial_sender #(
    parameter int BIT_CLKS = 16
) (
    input  logic clk,
    output logic rx_line
);
    // Bit time in clocks; the bench changes it to follow the baud setup
    int bit_clks = BIT_CLKS;
    initial rx_line = 1'b1;
    task automatic send(input logic [11:0] bits, input int n, input logic stop);
        rx_line <= 1'b0;
        repeat (bit_clks) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_line <= bits[i];
            repeat (bit_clks) @(posedge clk);
        end
        rx_line <= stop;
        repeat (bit_clks) @(posedge clk);
        rx_line <= 1'b1;
        repeat (bit_clks) @(posedge clk);
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [7:0] cfg;
        logic [8:0] ch;
        logic [7:0] fl;
        logic [7:0] st;
        logic [7:0] dt;
    } row_s;
    logic        clk, rst, cyc_i, stb_i, we_i, sleep_mode, ack_o, rx_line, irq_req, prio;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd;
    int          fails, total_checks;
    row_s        rows [6] = '{'{8'h90, 9'h0a5, 8'h20, 8'h90, 8'ha5},
        '{8'h90, 9'h0ff, 8'h20, 8'h90, 8'hff}, '{8'hd0, 9'h1c3, 8'h20, 8'hd1, 8'hc3},
        '{8'hd0, 9'h03c, 8'h20, 8'hd0, 8'h3c}, '{8'hd8, 9'h155, 8'h20, 8'hd9, 8'h55},
        '{8'hd8, 9'h0aa, 8'h00, 8'hd9, 8'h55}};
    uart_rx_wake uart_rx_wake_i (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_line(rx_line), .sleep_mode(sleep_mode), .irq_req(irq_req), .irq_high_prio(prio));
    serial_sender serial_sender_i (.clk(clk), .rx_line(rx_line));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard, well above the few thousand cycles the run needs
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        final_report();
    end
    task automatic final_report;
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then idle a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do @(posedge clk); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h0);
        chk(n, e, rd);
    endtask
    initial begin
        row_s r;
        rst <= 1'b1;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        adr_i <= 8'h0;
        dat_i <= 32'h0;
        sleep_mode <= 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // Reset contents, last word unmapped; only the idle flag reads set
        for (logic [7:0] a = 8'h0; a < 8'h2c; a += 8'h4) begin
            rc("reset", a, (a == 8'h1c) ? 32'h40 : 32'h0);
        end
        wb(1'b1, 8'h18, 8'h04);
        wb(1'b1, 8'h00, 8'hc0);
        wb(1'b1, 8'h08, 8'h20);
        wb(1'b1, 8'h0c, 8'h20);
        chk("priority", 32'h1, {31'h0, prio});
        foreach (rows[i]) begin
            r = rows[i];
            wb(1'b1, 8'h10, r.cfg);
            serial_sender_i.send({3'h0, r.ch}, r.cfg[6] ? 9 : 8, 1'b1);
            rc("flag", 8'h04, {24'h0, r.fl});
            chk("irq", {31'h0, r.fl[5]}, {31'h0, irq_req});
            rc("status", 8'h10, {24'h0, r.st});
            rc("data", 8'h14, {24'h0, r.dt});
        end
        // Bad stop, then a second character while the first is unread
        wb(1'b1, 8'h10, 8'h90);
        serial_sender_i.send(12'h0c3, 8, 1'b0);
        serial_sender_i.send(12'h011, 8, 1'b1);
        rc("errors", 8'h10, 32'h96);
        wb(1'b1, 8'h10, 8'h80);
        rc("errors off", 8'h10, 32'h80);
        rc("kept", 8'h14, 32'hc3);
        serial_sender_i.send(12'h05a, 8, 1'b1);
        rc("disabled", 8'h04, 32'h0);
        wb(1'b1, 8'h10, 8'h90);
        // Slower rates: wide counter, then the divided-down narrow one
        serial_sender_i.bit_clks = 64;
        wb(1'b1, 8'h24, 8'h03);
        wb(1'b1, 8'h1c, 8'h08);
        serial_sender_i.send(12'h0b4, 8, 1'b1);
        rc("wide rate", 8'h14, 32'hb4);
        wb(1'b1, 8'h24, 8'h00);
        wb(1'b1, 8'h1c, 8'h00);
        wb(1'b1, 8'h18, 8'h00);
        serial_sender_i.send(12'h069, 8, 1'b1);
        rc("slow rate", 8'h14, 32'h69);
        serial_sender_i.bit_clks = 16;
        wb(1'b1, 8'h18, 8'h04);
        sleep_mode <= 1'b1;
        serial_sender_i.send(12'h055, 8, 1'b1);
        rc("asleep", 8'h04, 32'h0);
        wb(1'b1, 8'h1c, 8'h02);
        serial_sender_i.send(12'h000, 12, 1'b1);
        rc("wake off", 8'h1c, 32'h40);
        rc("wake flag", 8'h04, 32'h20);
        chk("wake irq", 32'h1, {31'h0, irq_req});
        // Global enable off must mask a pending request
        wb(1'b1, 8'h00, 8'h40);
        chk("masked irq", 32'h0, {31'h0, irq_req});
        rc("wake status", 8'h10, 32'h90);
        wb(1'b0, 8'h14, 8'h0);
        rc("wake read", 8'h04, 32'h0);
        final_report();
    end
endmodule
